// ### common/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;
  localparam int unsigned N_CMP = 2;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COMPARATOR_ONE_CONTROL = 8'hac;
  localparam logic [7:0] IDX_COMPARATOR_TWO_CONTROL = 8'had;
  localparam logic [7:0] IDX_PT0  = 8'hf6;
  localparam logic [7:0] IDX_FIRST_IRQ_ENABLE_REG = 8'ha8;
  localparam logic [7:0] IDX_SECOND_IRQ_ENABLE_REG = 8'he8;
  localparam logic [7:0] IDX_EVTS = 8'hc0;
  localparam logic [7:0] IDX_EVTM = 8'hc1;
  // control register fields
  localparam int unsigned BIT_ON   = 5;
  localparam int unsigned BIT_POS  = 4;
  localparam int unsigned BIT_NEG  = 3;
  localparam int unsigned BIT_DRV  = 2;
  localparam int unsigned BIT_RES  = 1;
  localparam int unsigned BIT_FLAG = 0;
  // interrupt enable fields
  localparam int unsigned BIT_EA  = 7;
  localparam int unsigned BIT_EC1 = 5;
  localparam int unsigned BIT_EC2 = 2;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PT0  = 8'h00;
  localparam logic [7:0] RST_IEN  = 8'h00;
  localparam logic [7:0] RST_EVT  = 8'h00;
  // digital code standing for the internal reference voltage
  localparam logic [7:0] VREF_CODE = 8'h80;
  // startup time software must respect after enabling
  localparam int unsigned T_SETTLE_NS = 10000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SETTLE_CYCLES =
    (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### rtl/comparator_channel.sv
`timescale 1ns/1ns
`default_nettype none
module comparator_channel
  import cmp_ctrl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       on,
  input  wire logic       pos_sel,
  input  wire logic       neg_sel,
  input  wire logic       drv,
  input  wire logic [7:0] pos_a,
  input  wire logic [7:0] pos_b,
  input  wire logic [7:0] ref_pin,
  output logic            res,
  output logic            chg,
  output logic            pin_out,
  output logic            pin_oe
);
  logic [7:0] pos_lvl;
  logic [7:0] neg_lvl;
  logic       raw;
  logic       next_res;
  logic       next_chg;
  logic       next_pin_out;
  logic       next_pin_oe;

  always_comb begin
    pos_lvl      = pos_sel ? pos_b : pos_a;
    neg_lvl      = neg_sel ? VREF_CODE : ref_pin;
    raw          = pos_lvl > neg_lvl;
    next_res     = on & raw;
    // a change is only counted while on, so switching off never flags
    next_chg     = on & (raw != res);
    next_pin_oe  = on & drv;
    next_pin_out = on & drv & raw;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      res     <= 1'b0;
      chg     <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      res     <= next_res;
      chg     <= next_chg;
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_result_above: assert property (on && pos_lvl > neg_lvl |=> res)
    else $error("result not one with positive input above");
  a_result_below: assert property (!(pos_lvl > neg_lvl) |=> !res)
    else $error("result one without positive input above");
  a_pos_select: assert property (on && pos_sel && pos_b > neg_lvl
    |=> res)
    else $error("positive select not honoured");
  a_neg_internal: assert property (on && neg_sel && pos_lvl > VREF_CODE
    |=> res)
    else $error("internal reference not used");
endmodule
`default_nettype wire

// ### rtl/dual_comparator_control.sv
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  pos_a_one,
  input  wire logic [7:0]  pos_b_one,
  input  wire logic [7:0]  pos_a_two,
  input  wire logic [7:0]  pos_b_two,
  input  wire logic [7:0]  shared_reference_pin,
  input  wire logic [7:0]  port0_pins,
  input  wire logic        low_power,
  output logic             result_pin_one,
  output logic             result_pin_one_oe,
  output logic             result_pin_two,
  output logic             result_pin_two_oe,
  output logic [7:0]       port0_read,
  output logic [7:0]       port0_buf_en,
  output logic             irq,
  output logic             cpu_wake
);
  logic [N_CMP-1:0] comparator_on;
  logic [N_CMP-1:0] positive_input_select;
  logic [N_CMP-1:0] negative_input_select;
  logic [N_CMP-1:0] result_pin_drive;
  logic [N_CMP-1:0] result_change_flag;
  logic [N_CMP-1:0] comparator_irq_enable;
  logic             global_irq_enable;
  logic [7:0]       port0_input_disable;
  logic [N_CMP-1:0] evt_status;
  logic [N_CMP-1:0] evt_mask;

  logic [N_CMP-1:0] next_on;
  logic [N_CMP-1:0] next_pos;
  logic [N_CMP-1:0] next_neg;
  logic [N_CMP-1:0] next_drv;
  logic [N_CMP-1:0] next_flag;
  logic [N_CMP-1:0] next_ec;
  logic             next_ea;
  logic [7:0]       next_pt0;
  logic [N_CMP-1:0] next_evt_status;
  logic [N_CMP-1:0] next_evt_mask;
  logic             next_pready;
  logic [31:0]      next_prdata;
  logic             next_pslverr;
  logic [7:0]       next_port0_read;
  logic [7:0]       next_port0_buf_en;
  logic             next_irq;
  logic             next_cpu_wake;

  logic [N_CMP-1:0] synced_result;
  logic [N_CMP-1:0] chg;
  logic [N_CMP-1:0] pin_out;
  logic [N_CMP-1:0] pin_oe;
  logic [7:0]       pos_a [N_CMP];
  logic [7:0]       pos_b [N_CMP];

  logic [7:0]       idx;
  logic             aligned;
  logic             setup;
  logic             acc_wr;
  logic             acc_rd;
  logic [N_CMP-1:0] wsel_cmp;
  logic [7:0]       wbyte;
  logic [7:0]       rd_byte;
  logic             rd_hit;
  logic             cmp_req;

  assign pos_a[0] = pos_a_one;
  assign pos_b[0] = pos_b_one;
  assign pos_a[1] = pos_a_two;
  assign pos_b[1] = pos_b_two;

  // both channels are the same logic with their own control state
  genvar g;
  generate
    for (g = 0; g < N_CMP; g++) begin : g_cmp
      comparator_channel u_chan (
        .core_clk (core_clk),
        .rstn     (rstn),
        .on       (comparator_on[g]),
        .pos_sel  (positive_input_select[g]),
        .neg_sel  (negative_input_select[g]),
        .drv      (result_pin_drive[g]),
        .pos_a    (pos_a[g]),
        .pos_b    (pos_b[g]),
        .ref_pin  (shared_reference_pin),
        .res      (synced_result[g]),
        .chg      (chg[g]),
        .pin_out  (pin_out[g]),
        .pin_oe   (pin_oe[g])
      );
    end
  endgenerate

  assign result_pin_one    = pin_out[0];
  assign result_pin_one_oe = pin_oe[0];
  assign result_pin_two    = pin_out[1];
  assign result_pin_two_oe = pin_oe[1];

  // bus decode
  always_comb begin
    idx         = paddr[9:2];
    aligned     = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    setup       = psel & ~penable;
    acc_wr      = psel & penable & pready & pwrite;
    acc_rd      = psel & penable & pready & ~pwrite;
    wbyte       = pwdata[7:0];
    wsel_cmp[0] = acc_wr & aligned & (idx == IDX_COMPARATOR_ONE_CONTROL);
    wsel_cmp[1] = acc_wr & aligned & (idx == IDX_COMPARATOR_TWO_CONTROL);
    cmp_req     = global_irq_enable
                  & |(result_change_flag & comparator_irq_enable);
  end

  // read data is fetched in the setup cycle, so a read costs no wait
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = aligned;
    case (idx)
      IDX_COMPARATOR_ONE_CONTROL, IDX_COMPARATOR_TWO_CONTROL: begin
        rd_byte[BIT_ON]   = comparator_on[idx[0]];
        rd_byte[BIT_POS]  = positive_input_select[idx[0]];
        rd_byte[BIT_NEG]  = negative_input_select[idx[0]];
        rd_byte[BIT_DRV]  = result_pin_drive[idx[0]];
        rd_byte[BIT_RES]  = synced_result[idx[0]];
        rd_byte[BIT_FLAG] = result_change_flag[idx[0]];
      end
      IDX_PT0:  rd_byte = port0_input_disable;
      IDX_FIRST_IRQ_ENABLE_REG: rd_byte[BIT_EA] = global_irq_enable;
      IDX_SECOND_IRQ_ENABLE_REG: begin
        rd_byte[BIT_EC1] = comparator_irq_enable[0];
        rd_byte[BIT_EC2] = comparator_irq_enable[1];
      end
      IDX_EVTS: rd_byte[N_CMP-1:0] = evt_status;
      IDX_EVTM: rd_byte[N_CMP-1:0] = evt_mask;
      default:  rd_hit = 1'b0;
    endcase
    if (!aligned) begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    next_pready  = setup;
    next_prdata  = setup ? {24'h000000, rd_byte} : prdata;
    next_pslverr = setup & ~rd_hit;
  end

  always_comb begin
    next_on   = comparator_on;
    next_pos  = positive_input_select;
    next_neg  = negative_input_select;
    next_drv  = result_pin_drive;
    next_ec   = comparator_irq_enable;
    next_ea   = global_irq_enable;
    next_pt0  = port0_input_disable;
    next_evt_mask = evt_mask;
    for (int i = 0; i < N_CMP; i++) begin
      if (wsel_cmp[i]) begin
        next_on[i]  = wbyte[BIT_ON];
        next_pos[i] = wbyte[BIT_POS];
        next_neg[i] = wbyte[BIT_NEG];
        next_drv[i] = wbyte[BIT_DRV];
      end
      // writing zero clears the flag, a new change in that cycle wins
      next_flag[i] = chg[i] | (result_change_flag[i]
                     & ~(wsel_cmp[i] & ~wbyte[BIT_FLAG]));
    end
    if (acc_wr && aligned) begin
      case (idx)
        IDX_PT0:  next_pt0 = wbyte;
        IDX_FIRST_IRQ_ENABLE_REG: next_ea = wbyte[BIT_EA];
        IDX_SECOND_IRQ_ENABLE_REG: begin
          next_ec[0] = wbyte[BIT_EC1];
          next_ec[1] = wbyte[BIT_EC2];
        end
        IDX_EVTM: next_evt_mask = wbyte[N_CMP-1:0];
        default: ;
      endcase
    end
    // only bits actually returned are cleared; a newer event survives
    next_evt_status = chg | (evt_status
      & ~((acc_rd && aligned && idx == IDX_EVTS) ?
          prdata[N_CMP-1:0] : {N_CMP{1'b0}}));
  end

  always_comb begin
    next_port0_read   = port0_pins & ~port0_input_disable;
    next_port0_buf_en = ~port0_input_disable;
    next_irq          = cmp_req | |(evt_status & evt_mask);
    // no clock gating here: the channels run whatever the power mode
    next_cpu_wake     = low_power & cmp_req;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      comparator_on         <= {N_CMP{RST_CTRL[BIT_ON]}};
      positive_input_select <= {N_CMP{RST_CTRL[BIT_POS]}};
      negative_input_select <= {N_CMP{RST_CTRL[BIT_NEG]}};
      result_pin_drive      <= {N_CMP{RST_CTRL[BIT_DRV]}};
      result_change_flag    <= {N_CMP{RST_CTRL[BIT_FLAG]}};
      comparator_irq_enable <= {N_CMP{RST_IEN[BIT_EC1]}};
      global_irq_enable     <= RST_IEN[BIT_EA];
      port0_input_disable   <= RST_PT0;
      evt_status            <= RST_EVT[N_CMP-1:0];
      evt_mask              <= RST_EVT[N_CMP-1:0];
      pready                <= 1'b0;
      prdata                <= 32'h00000000;
      pslverr               <= 1'b0;
      port0_read            <= 8'h00;
      port0_buf_en          <= 8'h00;
      irq                   <= 1'b0;
      cpu_wake              <= 1'b0;
    end else begin
      comparator_on         <= next_on;
      positive_input_select <= next_pos;
      negative_input_select <= next_neg;
      result_pin_drive      <= next_drv;
      result_change_flag    <= next_flag;
      comparator_irq_enable <= next_ec;
      global_irq_enable     <= next_ea;
      port0_input_disable   <= next_pt0;
      evt_status            <= next_evt_status;
      evt_mask              <= next_evt_mask;
      pready                <= next_pready;
      prdata                <= next_prdata;
      pslverr               <= next_pslverr;
      port0_read            <= next_port0_read;
      port0_buf_en          <= next_port0_buf_en;
      irq                   <= next_irq;
      cpu_wake              <= next_cpu_wake;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_ctrl_enable: assert property (wsel_cmp[0] && wbyte[BIT_ON]
    |=> comparator_on[0])
    else $error("enable bit write not taken");
  a_flag_on_change: assert property (chg[1] |=> result_change_flag[1])
    else $error("change did not set flag");
  a_result_off_zero: assert property (!comparator_on[0]
    |=> !synced_result[0])
    else $error("result nonzero while off");
  a_pin_needs_on: assert property (result_pin_one_oe
    |-> $past(comparator_on[0] && result_pin_drive[0]))
    else $error("pin driven without enable");
  a_irq_raise: assert property (cmp_req |=> irq)
    else $error("comparator request not raised");
  a_irq_quiet: assert property (!cmp_req && !(|(evt_status & evt_mask))
    |=> !irq)
    else $error("interrupt without cause");
  a_port0_masked: assert property (1'b1
    |=> (port0_read & $past(port0_input_disable)) == 8'h00)
    else $error("disabled pin read nonzero");
  a_buffer_off: assert property (1'b1
    |=> port0_buf_en == ~$past(port0_input_disable))
    else $error("input buffer enable wrong");
  a_wake_change: assert property (low_power && cmp_req |=> cpu_wake)
    else $error("no wake on comparator request");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("access phase answer wrong");

  c_flag_set: cover property (chg[0] ##1 result_change_flag[0]);
  c_irq_up: cover property (!irq ##1 irq);
  c_status_clear: cover property (acc_rd && idx == IDX_EVTS
    && |evt_status);
  c_pin_drive: cover property (result_pin_two_oe && result_pin_two);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import cmp_ctrl_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0]  pa [2] = '{8'h00, 8'h00};
  logic [7:0]  pb [2] = '{8'h00, 8'h00};
  logic [7:0]  ref_code = 8'h40;
  logic [7:0]  pins = 8'h00;
  logic        low_power = 1'b0;
  wire logic        pready;
  wire logic [31:0] prdata;
  wire logic        pslverr;
  wire logic [1:0]  rp;
  wire logic [1:0]  roe;
  wire logic [7:0]  p0r;
  wire logic [7:0]  p0b;
  wire logic        irq;
  wire logic        wake;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [7:0]  ridx [7] = '{IDX_COMPARATOR_ONE_CONTROL, IDX_COMPARATOR_TWO_CONTROL, IDX_PT0, IDX_FIRST_IRQ_ENABLE_REG, IDX_SECOND_IRQ_ENABLE_REG,
                            IDX_EVTS, IDX_EVTM};

  dual_comparator_control dual_comparator_control_inst (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pos_a_one(pa[0]),
    .pos_b_one(pb[0]), .pos_a_two(pa[1]), .pos_b_two(pb[1]),
    .shared_reference_pin(ref_code), .port0_pins(pins),
    .low_power(low_power), .result_pin_one(rp[0]),
    .result_pin_one_oe(roe[0]), .result_pin_two(rp[1]),
    .result_pin_two_oe(roe[1]), .port0_read(p0r), .port0_buf_en(p0b),
    .irq(irq), .cpu_wake(wake));

  always #50 core_clk = ~core_clk;

  task automatic test_done();
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut short far beyond the fewer than a thousand cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check_reg(input string n, input logic [31:0] e,
                           input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_pin(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  // entered just after a rising edge; leaves one edge after release
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a missing answer is a fault of its own, not only a wrong data word
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd(input string n, input logic [7:0] idx,
                    input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    check_reg(n, {24'h000000, e}, rdata);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic test_cmp(input int c);
    logic [7:0] ci;
    logic [7:0] en;
    ci = (c == 0) ? IDX_COMPARATOR_ONE_CONTROL : IDX_COMPARATOR_TWO_CONTROL;
    en = 8'(1 << ((c == 0) ? BIT_EC1 : BIT_EC2));
    pa[c] <= 8'h90;
    pb[c] <= 8'h10;
    wr(ci, 8'h24);
    cyc(SETTLE_CYCLES);
    wr(ci, 8'h24);
    cyc(4);
    rd("ctrl on", ci, 8'h26);
    check_pin("pin", 1'b1, rp[c]);
    check_pin("pin oe", 1'b1, roe[c]);
    pa[c] <= 8'h40;
    cyc(4);
    rd("equal", ci, 8'h25);
    check_pin("pin", 1'b0, rp[c]);
    wr(ci, 8'h34);
    pb[c] <= 8'h41;
    cyc(4);
    rd("pos b", ci, 8'h37);
    wr(ci, 8'h2c);
    cyc(4);
    wr(ci, 8'h2c);
    pa[c] <= VREF_CODE;
    cyc(4);
    rd("vref equal", ci, 8'h2c);
    pa[c] <= VREF_CODE + 8'h01;
    cyc(4);
    rd("vref above", ci, 8'h2f);
    wr(ci, 8'h2f);
    rd("flag kept", ci, 8'h2f);
    wr(ci, 8'h04);
    cyc(2);
    rd("off", ci, 8'h04);
    check_pin("pin oe", 1'b0, roe[c]);
    pa[c] <= 8'h90;
    wr(ci, 8'h24);
    cyc(SETTLE_CYCLES);
    wr(ci, 8'h24);
    xfer(1'b0, IDX_EVTS, 8'h00);
    wr(IDX_SECOND_IRQ_ENABLE_REG, en);
    wr(IDX_FIRST_IRQ_ENABLE_REG, 8'h80);
    cyc(2);
    check_pin("irq quiet", 1'b0, irq);
    pa[c] <= 8'h10;
    cyc(5);
    check_pin("irq", 1'b1, irq);
    low_power <= 1'b1;
    cyc(3);
    check_pin("wake", 1'b1, wake);
    low_power <= 1'b0;
    wr(IDX_FIRST_IRQ_ENABLE_REG, 8'h00);
    cyc(2);
    check_pin("irq off", 1'b0, irq);
    wr(IDX_SECOND_IRQ_ENABLE_REG, 8'h00);
    wr(ci, 8'h24);
    xfer(1'b0, IDX_EVTS, 8'h00);
    wr(IDX_EVTM, 8'(1 << c));
    pa[c] <= 8'h90;
    cyc(5);
    check_pin("irq evt", 1'b1, irq);
    rd("status", IDX_EVTS, 8'(1 << c));
    cyc(2);
    check_pin("irq clr", 1'b0, irq);
    wr(IDX_EVTM, 8'h00);
    wr(ci, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    foreach (ridx[i]) rd("reset", ridx[i], 8'h00);
    xfer(1'b0, 8'h00, 8'h00);
    check_pin("slverr", 1'b1, rerr);
    check_reg("unmapped", 32'h00000000, rdata);
    wr(IDX_SECOND_IRQ_ENABLE_REG, 8'hff);
    rd("second_irq_enable_reg", IDX_SECOND_IRQ_ENABLE_REG, 8'h24);
    wr(IDX_FIRST_IRQ_ENABLE_REG, 8'hff);
    rd("first_irq_enable_reg", IDX_FIRST_IRQ_ENABLE_REG, 8'h80);
    wr(IDX_FIRST_IRQ_ENABLE_REG, 8'h00);
    wr(IDX_SECOND_IRQ_ENABLE_REG, 8'h00);
    pins <= 8'hff;
    wr(IDX_PT0, 8'h30);
    cyc(3);
    rd("pt0", IDX_PT0, 8'h30);
    check_reg("port0 read", 32'h000000cf, {24'h000000, p0r});
    check_reg("buf en", 32'h000000cf, {24'h000000, p0b});
    for (int c = 0; c < N_CMP; c++) test_cmp(c);
    test_done();
  end
endmodule
`default_nettype wire
